/* File: core/cmc_ctrl.sv */
// cmc_ctrl: host-side controller for a clock manager's reset, phase-shift
// and reconfiguration ports, commanded over an APB slave.
// assumes: device pins are asynchronous to pclk; link clocks are made here.
`timescale 1ns/1ps
`default_nettype none

module cmc_ctrl #(
    parameter int HALF_DIV = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cmc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic src_clk,
    input wire logic dev_locked,
    output logic dev_rst,
    output logic shift_clk,
    output logic shift_dir,
    output logic shift_req,
    input wire logic shift_done,
    output logic recfg_clk,
    output logic [cmc_pkg::RC_ADDR_W-1:0] recfg_addr,
    output logic [cmc_pkg::RC_DATA_W-1:0] recfg_wdata,
    output logic recfg_wr_en,
    output logic recfg_access_en,
    input wire logic recfg_ack,
    input wire logic [cmc_pkg::RC_DATA_W-1:0] recfg_rdata
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // two cycles per half period keep the falling and rising ticks apart
    if (HALF_DIV < 2 || HALF_DIV > 255) begin : g_bad_div
        $error("cmc_ctrl: HALF_DIV must lie in 2..255");
    end

    localparam logic [cmc_pkg::DIV_W-1:0] DIV_LAST =
        cmc_pkg::DIV_W'(HALF_DIV - 1);

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == cmc_pkg::OFS_CTRL) || (a == cmc_pkg::OFS_STATUS) ||
                     (a == cmc_pkg::OFS_SHIFT) || (a == cmc_pkg::OFS_RECFG) ||
                     (a == cmc_pkg::OFS_RDATA);
    endfunction

    cmc_pkg::cmc_state_s q, d;

    logic tick, rise_tick, fall_tick, src_edge, done_edge, ack_edge;
    logic apb_acc, apb_wr, shift_on, recfg_on, locked;
    logic [31:0] status_w, rd_w;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        tick = (q.div == DIV_LAST);
        rise_tick = tick && !q.lclk;
        fall_tick = tick && q.lclk;
        src_edge = q.src_s2 && !q.src_prev;
        done_edge = q.done_s2 && !q.done_prev;
        ack_edge = q.ack_s2 && !q.ack_prev;
        shift_on = q.ctrl[cmc_pkg::CTRL_SHIFT_EN];
        recfg_on = q.ctrl[cmc_pkg::CTRL_RECFG_EN];
        locked = q.lock_s2 && !q.dev_rst;
        apb_acc = psel && penable && !q.pready;
        apb_wr = psel && penable && q.pready && pwrite;

        // two-flop synchronisers for every device pin
        d.src_s1 = src_clk;
        d.src_s2 = q.src_s1;
        d.src_prev = q.src_s2;
        d.done_s1 = shift_done;
        d.done_s2 = q.done_s1;
        d.done_prev = q.done_s2;
        d.ack_s1 = recfg_ack;
        d.ack_s2 = q.ack_s1;
        d.ack_prev = q.ack_s2;
        d.lock_s1 = dev_locked;
        d.lock_s2 = q.lock_s1;
        d.rd_s1 = recfg_rdata;
        d.rd_s2 = q.rd_s1;

        // link clock divider, shared by both device clock pins
        d.div = tick ? '0 : q.div + 1'b1;
        d.lclk = tick ? !q.lclk : q.lclk;
        d.shift_clk = d.lclk && shift_on;
        d.recfg_clk = d.lclk && recfg_on;

        // reset release: hold reset until three source edges are seen
        if (q.ctrl[cmc_pkg::CTRL_HOLD_RST]) begin
            d.dev_rst = 1'b1;
            d.src_cnt = '0;
        end else if (q.dev_rst && src_edge) begin
            if (q.src_cnt == cmc_pkg::SRC_EDGES_M1) begin
                d.dev_rst = 1'b0;
            end else begin
                d.src_cnt = q.src_cnt + 1'b1;
            end
        end

        // shift sequencer: pins move only at the link falling tick
        case (q.sh_st)
            cmc_pkg::SH_IDLE: begin
                d.shift_req = 1'b0;
            end
            cmc_pkg::SH_ARM: begin
                if (fall_tick) begin
                    d.shift_dir = q.pend_dir;
                    d.shift_req = 1'b1;
                    d.sh_st = cmc_pkg::SH_REQ;
                end
            end
            cmc_pkg::SH_REQ: begin
                // one period: drop at the next falling tick
                if (fall_tick) begin
                    d.shift_req = 1'b0;
                    d.sh_st = cmc_pkg::SH_WAIT;
                end
            end
            cmc_pkg::SH_WAIT: begin
                // wait for done; done frees the sequencer
                if (done_edge) begin
                    d.sh_st = cmc_pkg::SH_IDLE;
                end
            end
            default: d.sh_st = cmc_pkg::SH_IDLE;
        endcase

        // recfg sequencer: one enable period, then wait for ready
        case (q.rc_st)
            cmc_pkg::RC_IDLE: begin
                d.rc_en = 1'b0;
            end
            cmc_pkg::RC_ARM: begin
                if (fall_tick) begin
                    d.rc_en = 1'b1;
                    d.rc_we = q.rc_cmd[cmc_pkg::RC_WRITE_BIT];
                    d.rc_addr = q.rc_cmd[cmc_pkg::RC_ADDR_LSB +: 7];
                    d.rc_wdata = q.rc_cmd[cmc_pkg::RC_WDATA_LSB +: 16];
                    d.rc_st = cmc_pkg::RC_EN;
                end
            end
            cmc_pkg::RC_EN: begin
                if (fall_tick) begin
                    // back to address zero so status shows again
                    d.rc_en = 1'b0;
                    d.rc_we = 1'b0;
                    d.rc_addr = '0;
                    // write data zero outside the window
                    d.rc_wdata = '0;
                    d.rc_st = cmc_pkg::RC_WAIT;
                end
            end
            cmc_pkg::RC_WAIT: begin
                if (ack_edge) begin
                    d.rc_rdata = q.rd_s2;
                    d.rc_st = cmc_pkg::RC_IDLE;
                end
            end
            default: d.rc_st = cmc_pkg::RC_IDLE;
        endcase

        // status word; device status bits are valid only while idle
        status_w = '0;
        status_w[cmc_pkg::ST_DEV_RST] = q.dev_rst;
        status_w[cmc_pkg::ST_LOCKED] = locked;
        status_w[cmc_pkg::ST_SHIFT_BUSY] = (q.sh_st != cmc_pkg::SH_IDLE);
        status_w[cmc_pkg::ST_RECFG_BUSY] = (q.rc_st != cmc_pkg::RC_IDLE);
        status_w[cmc_pkg::ST_SHIFT_DONE] = q.shift_flag;
        status_w[cmc_pkg::ST_RECFG_DONE] = q.rc_flag;
        // overflow and stopped, read from the idle status word
        if (recfg_on && q.rc_st == cmc_pkg::RC_IDLE) begin
            status_w[cmc_pkg::ST_OVERFLOW] = q.rd_s2[cmc_pkg::DEV_OVERFLOW_BIT];
            status_w[cmc_pkg::ST_SRC_STOP] = q.rd_s2[cmc_pkg::DEV_SRC_STOP_BIT];
        end

        // APB read data chosen during the wait cycle
        case (paddr)
            cmc_pkg::OFS_CTRL: rd_w = {29'h0, q.ctrl};
            cmc_pkg::OFS_STATUS: rd_w = status_w;
            cmc_pkg::OFS_SHIFT: rd_w = {31'h0, q.pend_dir};
            cmc_pkg::OFS_RECFG: rd_w = {7'h0, q.rc_cmd};
            cmc_pkg::OFS_RDATA: rd_w = {16'h0, q.rc_rdata};
            default: rd_w = '0;
        endcase
        d.pready = apb_acc;
        d.pslverr = apb_acc && !addr_known(paddr);
        d.prdata = (apb_acc && !pwrite) ? rd_w : '0;

        // done flags: the hardware set wins over a software clear
        if (apb_wr && paddr == cmc_pkg::OFS_STATUS) begin
            if (pwdata[cmc_pkg::ST_SHIFT_DONE]) d.shift_flag = 1'b0;
            if (pwdata[cmc_pkg::ST_RECFG_DONE]) d.rc_flag = 1'b0;
        end
        if (q.sh_st == cmc_pkg::SH_WAIT && done_edge) d.shift_flag = 1'b1;
        if (q.rc_st == cmc_pkg::RC_WAIT && ack_edge) d.rc_flag = 1'b1;

        // register writes; commands while busy are ignored, shift commands also while unlocked
        if (apb_wr && paddr == cmc_pkg::OFS_CTRL) begin
            d.ctrl = pwdata[2:0];
        end
        if (apb_wr && paddr == cmc_pkg::OFS_SHIFT && shift_on && locked &&
            q.sh_st == cmc_pkg::SH_IDLE) begin
            d.pend_dir = pwdata[cmc_pkg::SHIFT_DIR_BIT];
            d.sh_st = cmc_pkg::SH_ARM;
        end
        if (apb_wr && paddr == cmc_pkg::OFS_RECFG && recfg_on &&
            q.rc_st == cmc_pkg::RC_IDLE) begin
            d.rc_cmd = pwdata[24:0];
            d.rc_st = cmc_pkg::RC_ARM;
        end

        // switching shifting off parks every shift pin low
        if (!d.ctrl[cmc_pkg::CTRL_SHIFT_EN]) begin
            d.sh_st = cmc_pkg::SH_IDLE;
            d.shift_req = 1'b0;
            d.shift_dir = 1'b0;
            d.shift_clk = 1'b0;
        end
        // switching reconfiguration off zeroes the whole port
        if (!d.ctrl[cmc_pkg::CTRL_RECFG_EN]) begin
            d.rc_st = cmc_pkg::RC_IDLE;
            d.rc_en = 1'b0;
            d.rc_we = 1'b0;
            d.rc_addr = '0;
            d.rc_wdata = '0;
            d.recfg_clk = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // device held in reset from our own reset onward
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.ctrl <= cmc_pkg::CTRL_RESET;
            q.dev_rst <= 1'b1;
            q.sh_st <= cmc_pkg::SH_IDLE;
            q.rc_st <= cmc_pkg::RC_IDLE;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign dev_rst = q.dev_rst;
    assign shift_clk = q.shift_clk;
    assign shift_dir = q.shift_dir;
    assign shift_req = q.shift_req;
    assign recfg_clk = q.recfg_clk;
    assign recfg_addr = q.rc_addr;
    assign recfg_wdata = q.rc_wdata;
    assign recfg_wr_en = q.rc_we;
    assign recfg_access_en = q.rc_en;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence src_third_edge;
        $past(q.src_cnt) == 2'h2 && $past(q.src_s2) && !$past(q.src_prev);
    endsequence

    // release only after the third edge
    rst_release_a: assert property ($fell(q.dev_rst) |-> src_third_edge)
        else $error("device reset released too early");
    shift_park_a: assert property (!q.ctrl[1] |->
        !q.shift_clk && !q.shift_req && !q.shift_dir)
        else $error("shift pins active while shifting is off");
    // request edges only while shift clock is low
    req_sync_a: assert property ($changed(q.shift_req) |-> !q.shift_clk)
        else $error("shift request moved with shift clock high");
    req_width_a: assert property ($rose(q.shift_req) |->
        q.shift_req[*8] ##1 !q.shift_req)
        else $error("shift request width wrong");
    // no request while waiting for done
    shift_wait_a: assert property (q.sh_st == cmc_pkg::SH_WAIT |->
        !q.shift_req)
        else $error("shift request while previous one pending");
    done_flag_a: assert property (q.sh_st == cmc_pkg::SH_WAIT &&
        q.done_s2 && !q.done_prev |=> q.shift_flag && q.sh_st == cmc_pkg::SH_IDLE)
        else $error("shift done not recorded");
    // port zero while reconfiguration is off
    recfg_park_a: assert property (!q.ctrl[2] |-> !q.recfg_clk &&
        !q.rc_en && !q.rc_we && q.rc_addr == '0 && q.rc_wdata == '0)
        else $error("recfg pins active while unused");
    // enable lasts one link period, then waits for ready
    en_width_a: assert property ($rose(q.rc_en) |->
        q.rc_en[*8] ##1 (!q.rc_en && q.rc_st == cmc_pkg::RC_WAIT))
        else $error("access enable width wrong");
    // write enable only rides on an access
    we_with_en_a: assert property (q.rc_we |-> q.rc_en)
        else $error("write enable without access enable");
    // address back to zero when no access runs
    addr_idle_a: assert property (!q.rc_en |-> q.rc_addr == '0)
        else $error("address not zero between accesses");
    // apb answer lasts one cycle
    apb_ready_a: assert property (q.pready |=> !q.pready)
        else $error("pready held for more than one cycle");

endmodule // cmc_ctrl

`default_nettype wire

/* File: core/cmc_pkg.sv */
// cmc_pkg: constants, register map and state record of the clock manager
// controller.
// assumes: APB slave on pclk at 50 MHz; device pins reached directly.
package cmc_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets, one word each)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SHIFT = 8'h08;
    localparam logic [7:0] OFS_RECFG = 8'h0c;
    localparam logic [7:0] OFS_RDATA = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_HOLD_RST = 0;
    localparam int CTRL_SHIFT_EN = 1;
    localparam int CTRL_RECFG_EN = 2;
    localparam int ST_DEV_RST = 0;
    localparam int ST_LOCKED = 1;
    localparam int ST_SHIFT_BUSY = 2;
    localparam int ST_RECFG_BUSY = 3;
    localparam int ST_SHIFT_DONE = 4;
    localparam int ST_RECFG_DONE = 5;
    localparam int ST_OVERFLOW = 6;
    localparam int ST_SRC_STOP = 7;
    localparam int SHIFT_DIR_BIT = 0;
    localparam int RC_WDATA_LSB = 0;
    localparam int RC_ADDR_LSB = 16;
    localparam int RC_WRITE_BIT = 24;
    // device status word bits shown while the port is idle
    localparam int DEV_OVERFLOW_BIT = 0;
    localparam int DEV_SRC_STOP_BIT = 1;

    // ------------------------------------------------------------
    // widths, reset values and counts
    // ------------------------------------------------------------
    localparam int RC_DATA_W = 16;
    localparam int RC_ADDR_W = 7;
    localparam int DIV_W = 8;
    localparam logic [1:0] SRC_EDGES_M1 = 2'h2; // three stable edges
    localparam logic [2:0] CTRL_RESET = 3'h1;   // hold device in reset

    typedef enum logic [1:0] {SH_IDLE, SH_ARM, SH_REQ, SH_WAIT} cmc_shift_e;
    typedef enum logic [1:0] {RC_IDLE, RC_ARM, RC_EN, RC_WAIT} cmc_recfg_e;

    // ------------------------------------------------------------
    // whole state of the controller
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] ctrl;
        logic dev_rst;
        logic src_s1;
        logic src_s2;
        logic src_prev;
        logic [1:0] src_cnt;
        logic [DIV_W-1:0] div;
        logic lclk;
        logic shift_clk;
        logic recfg_clk;
        cmc_shift_e sh_st;
        logic shift_req;
        logic shift_dir;
        logic pend_dir;
        logic done_s1;
        logic done_s2;
        logic done_prev;
        logic shift_flag;
        cmc_recfg_e rc_st;
        logic rc_en;
        logic rc_we;
        logic [RC_ADDR_W-1:0] rc_addr;
        logic [RC_DATA_W-1:0] rc_wdata;
        logic [24:0] rc_cmd;
        logic ack_s1;
        logic ack_s2;
        logic ack_prev;
        logic [RC_DATA_W-1:0] rc_rdata;
        logic rc_flag;
        logic lock_s1;
        logic lock_s2;
        logic [RC_DATA_W-1:0] rd_s1;
        logic [RC_DATA_W-1:0] rd_s2;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cmc_state_s;

endpackage

/* File: verif/cmc_dev_model.sv */
// cmc_dev_model: behavioural clock manager seen from its control pins.
// assumes: driven by cmc_ctrl; the bench may halt the source clock.
`timescale 1ns/1ps
`default_nettype none
module cmc_dev_model #(
    parameter int LOCK_EDGES = 6,
    parameter int DONE_WAIT = 3,
    parameter int PHASE_MAX = 2
) (
    input wire logic dev_rst,
    input wire logic src_halt,
    input wire logic shift_clk,
    input wire logic shift_dir,
    input wire logic shift_req,
    input wire logic recfg_clk,
    input wire logic [6:0] recfg_addr,
    input wire logic [15:0] recfg_wdata,
    input wire logic recfg_wr_en,
    input wire logic recfg_access_en,
    output logic src_clk,
    output logic dev_locked,
    output logic shift_done,
    output logic recfg_ack,
    output logic [15:0] recfg_rdata,
    output var int phase
);
    logic [15:0] mem [0:127];
    logic [15:0] rd;
    logic [15:0] stat;
    logic [6:0] ad;
    logic pend;
    logic stop;
    int lk;
    int sw;

    // a halted source keeps its last level, like a stopped oscillator
    initial src_clk = 1'b0;
    initial stop = 1'b0;
    always #80 if (!src_halt) src_clk = ~src_clk;
    // stop flag trails the halt by four source periods
    always @(src_halt) stop <= #640 src_halt;

    always @(posedge src_clk or posedge dev_rst) begin
        if (dev_rst) begin
            lk = 0;
            dev_locked = 1'b0;
        end else if (lk < LOCK_EDGES)
            lk++;
        else
            dev_locked = 1'b1;
    end

    always @(posedge shift_clk or posedge dev_rst) begin
        if (dev_rst) begin
            sw = 0;
            phase = 0;
            shift_done = 1'b0;
        end else begin
            shift_done = 1'b0;
            if (sw != 0) begin
                sw--;
                shift_done = (sw == 0);
                // a request held too long or repeated early spoils phase
                if (shift_req)
                    phase = 99;
            end else if (shift_req) begin
                phase += shift_dir ? 1 : -1;
                sw = DONE_WAIT;
            end
        end
    end

    assign stat = {14'h0, stop, (phase > PHASE_MAX || phase < -PHASE_MAX)};

    // store only when enabled, ack one period
    always @(posedge recfg_clk or posedge dev_rst) begin
        if (dev_rst) begin
            pend = 1'b0;
            recfg_ack = 1'b0;
        end else begin
            recfg_ack = pend;
            rd = mem[ad];
            pend = recfg_access_en && !pend;
            if (pend)
                ad = recfg_addr;
            if (pend && recfg_wr_en)
                mem[ad] = recfg_wdata;
        end
    end

    // status when idle; junk while an access is pending
    assign recfg_rdata = dev_rst ? 16'h0 : recfg_ack ? rd : pend ? ~rd : stat;
endmodule // cmc_dev_model
`default_nettype wire

/* File: verif/test_cmc_ctrl.sv */
// test_cmc_ctrl: APB-driven checks of the clock manager controller.
// assumes: cmc_ctrl with HALF_DIV 4 and the behavioural device model.
`timescale 1ns/1ps
`default_nettype none
module test_cmc_ctrl;
    logic pclk, presetn, psel, penable, pwrite, src_halt, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err, src_clk, dev_locked, dev_rst, shift_clk, shift_dir, shift_req;
    logic shift_done, recfg_clk, recfg_wr_en, recfg_access_en, recfg_ack;
    logic [6:0] recfg_addr;
    logic [15:0] recfg_wdata, recfg_rdata;
    int phase, failures, checks;

    cmc_ctrl #(.HALF_DIV(4)) i_cmc_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_clk(src_clk),
        .dev_locked(dev_locked), .dev_rst(dev_rst), .shift_clk(shift_clk),
        .shift_dir(shift_dir), .shift_req(shift_req),
        .shift_done(shift_done), .recfg_clk(recfg_clk),
        .recfg_addr(recfg_addr), .recfg_wdata(recfg_wdata),
        .recfg_wr_en(recfg_wr_en), .recfg_access_en(recfg_access_en),
        .recfg_ack(recfg_ack), .recfg_rdata(recfg_rdata)
    );
    cmc_dev_model i_cmc_dev_model (
        .dev_rst(dev_rst), .src_halt(src_halt), .shift_clk(shift_clk),
        .shift_dir(shift_dir), .shift_req(shift_req),
        .recfg_clk(recfg_clk), .recfg_addr(recfg_addr),
        .recfg_wdata(recfg_wdata), .recfg_wr_en(recfg_wr_en),
        .recfg_access_en(recfg_access_en), .src_clk(src_clk),
        .dev_locked(dev_locked), .shift_done(shift_done),
        .recfg_ack(recfg_ack), .recfg_rdata(recfg_rdata), .phase(phase)
    );

    // 50 MHz register clock
    always #10 pclk = ~pclk;

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one APB transfer; pready, prdata and pslverr are taken at the rising
    // edge, before that edge's updates land
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                failures++;
                $display("Error pready expected 1 seen %h", pready);
                complete_run();
            end
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // poll a status bit under a bounded count
    task automatic wait_bit(input int idx, input logic v);
        for (int n = 0; n < 100; n++) begin
            apb(1'b0, cmc_pkg::OFS_STATUS, 32'h0);
            if (rd[idx] === v)
                return;
        end
        failures++;
        $display("Error status bit %0d expected %h seen %h", idx, v, rd[idx]);
        complete_run();
    endtask

    task automatic shift(input logic dir);
        apb(1'b1, cmc_pkg::OFS_SHIFT, {31'h0, dir});
        wait_bit(cmc_pkg::ST_SHIFT_DONE, 1'b1);
        apb(1'b1, cmc_pkg::OFS_STATUS, 32'h10);
    endtask

    task automatic recfg(input logic we, input logic [6:0] a,
                         input logic [15:0] d);
        apb(1'b1, cmc_pkg::OFS_RECFG, {7'h0, we, 1'b0, a, d});
        wait_bit(cmc_pkg::ST_RECFG_DONE, 1'b1);
        apb(1'b1, cmc_pkg::OFS_STATUS, 32'h20);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        src_halt = 1'b0;
        failures = 0;
        checks = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reset values; every link pin parked low
        apb(1'b0, cmc_pkg::OFS_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h1);
        chk("dev_rst pin", {31'h0, dev_rst}, 32'h1);
        chk("idle pins", {3'h0, shift_clk, shift_dir, shift_req, recfg_clk,
            recfg_wr_en, recfg_access_en, recfg_addr, recfg_wdata},
            32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        // a shift while the feature is off must not reach the device
        apb(1'b1, cmc_pkg::OFS_SHIFT, 32'h1);
        apb(1'b0, cmc_pkg::OFS_STATUS, 32'h0);
        chk("refused busy", {31'h0, rd[cmc_pkg::ST_SHIFT_BUSY]}, 32'h0);
        chk("refused phase", phase, 32'h0);
        // release: reset must outlast three source edges
        apb(1'b1, cmc_pkg::OFS_CTRL, 32'h6);
        chk("dev_rst held", {31'h0, dev_rst}, 32'h1);
        wait_bit(cmc_pkg::ST_LOCKED, 1'b1);
        chk("dev_rst released", {31'h0, dev_rst}, 32'h0);
        // three steps up pass the limit, one down comes back
        repeat (3) shift(1'b1);
        chk("phase up", phase, 32'h3);
        apb(1'b0, cmc_pkg::OFS_STATUS, 32'h0);
        chk("overflow set", {31'h0, rd[cmc_pkg::ST_OVERFLOW]}, 32'h1);
        shift(1'b0);
        chk("phase down", phase, 32'h2);
        apb(1'b0, cmc_pkg::OFS_STATUS, 32'h0);
        chk("overflow clear", {31'h0, rd[cmc_pkg::ST_OVERFLOW]}, 32'h0);
        chk("done flags", {30'h0, rd[5:4]}, 32'h0);
        apb(1'b0, cmc_pkg::OFS_SHIFT, 32'h0);
        chk("dir readback", rd, 32'h0);
        // writes at both ends of the address range, then read back
        recfg(1'b1, 7'h7f, 16'ha5c3);
        recfg(1'b1, 7'h00, 16'h0f0f);
        recfg(1'b0, 7'h7f, 16'h0);
        apb(1'b0, cmc_pkg::OFS_RDATA, 32'h0);
        chk("recfg read hi", rd, 32'ha5c3);
        recfg(1'b0, 7'h00, 16'h0);
        apb(1'b0, cmc_pkg::OFS_RDATA, 32'h0);
        chk("recfg read lo", rd, 32'h0f0f);
        // halted source shows in status, clears when it runs again
        src_halt <= 1'b1;
        wait_bit(cmc_pkg::ST_SRC_STOP, 1'b1);
        chk("src stop", {31'h0, rd[cmc_pkg::ST_SRC_STOP]}, 32'h1);
        src_halt <= 1'b0;
        wait_bit(cmc_pkg::ST_SRC_STOP, 1'b0);
        chk("src run", {31'h0, rd[cmc_pkg::ST_SRC_STOP]}, 32'h0);
        // features off again: link pins park low
        apb(1'b1, cmc_pkg::OFS_CTRL, 32'h0);
        repeat (16) @(posedge pclk);
        chk("parked pins", {3'h0, shift_clk, shift_dir, shift_req, recfg_clk,
            recfg_wr_en, recfg_access_en, recfg_addr, recfg_wdata},
            32'h0);
        complete_run();
    end
endmodule // test_cmc_ctrl
`default_nettype wire
